// ==== logic/ovh_port_pkg.sv ====
// constants shared by the serial overhead access ports
package ovh_port_pkg;
  // lane numbering, shared by the transmit and receive sides
  localparam int LANES = 5;
  localparam int LANE_TOH = 0;
  localparam int LANE_OW = 1;
  localparam int LANE_SDCC = 2;
  localparam int LANE_LDCC = 3;
  localparam int LANE_POH = 4;
  // widths of the serial position counter and of a byte
  localparam int POS_W = 11;
  localparam int BYTE_BITS = 8;
  localparam int IDX_W = 8;
  // bit slots per frame on each port clock
  localparam int TOH_FRAME_BITS = 1944;
  localparam int POH_FRAME_BITS = 72;
  localparam int LANE_FRAME_BITS [LANES] = '{TOH_FRAME_BITS, TOH_FRAME_BITS,
                                             TOH_FRAME_BITS, TOH_FRAME_BITS,
                                             POH_FRAME_BITS};
  // first bit slot and length in bits of each lane's window
  localparam int LANE_START [LANES] = '{0, 48, 432, 1080, 0};
  localparam int LANE_LEN [LANES] = '{1944, 24, 24, 72, 72};
  // lanes clocked by the path overhead port clock
  localparam bit LANE_ON_POH [LANES] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // order of the pins in the synchroniser vector
  localparam int PIN_COUNT = 11;
  localparam int PIN_TX_TOH_CLK = 0;
  localparam int PIN_TX_POH_CLK = 1;
  localparam int PIN_RX_TOH_CLK = 2;
  localparam int PIN_RX_POH_CLK = 3;
  localparam int PIN_TOH_REQ = 4;
  localparam int PIN_TOH_DATA = 5;
  localparam int PIN_POH_REQ = 6;
  localparam int PIN_POH_DATA = 7;
  localparam int PIN_OW_DATA = 8;
  localparam int PIN_SDCC_DATA = 9;
  localparam int PIN_LDCC_DATA = 10;
endpackage

// ==== logic/pin_sync.sv ====
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] PIN,
  output logic [WIDTH-1:0] LEVEL,
  output logic [WIDTH-1:0] RISE,
  output logic [WIDTH-1:0] FALL
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // synchroniser chain, first stage feeds only the second
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= PIN;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level moves only where stages two and three agree
  always_comb begin
    level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  // one-cycle edge pulses, combinational
  assign LEVEL = level_reg;
  assign RISE = level_next & ~level_reg;
  assign FALL = ~level_next & level_reg;
endmodule
`default_nettype wire

// ==== logic/overhead_ports.sv ====
// serial transmit and receive overhead access ports on one core clock
// Summary of operation
// - tx transport port hands user bytes to the inserter
// - transport request and data sampled on port clock rise
// - transport mark and enable change on port clock fall
// - tx path port hands user path bytes to the inserter
// - path request and data sampled on path clock rise
// - path mark, enable, valid change on path clock fall
// - orderwire input sampled on transport clock rise
// - orderwire enable and mark change on transport clock fall
// - section dcc input sampled on transport clock rise
// - section dcc enable changes on transport clock fall
// - line dcc input sampled on transport clock rise
// - line dcc enable changes on transport clock fall
// - rx transport outputs extracted bytes on falling edge
// - rx transport gives frame mark and valid with data
// - rx path gives data, mark, valid on falling edge
// - rx orderwire gives data, mark, valid on falling edge
// - rx section dcc gives data and valid on falling edge
// - rx line dcc outputs change on transport clock fall
`timescale 1ns/1ns
`default_nettype none
module overhead_ports (
  input wire logic CLK,
  input wire logic RST,
  // transmit serial pins
  input wire logic TX_TRANSPORT_OVH_CLOCK,
  input wire logic TX_TRANSPORT_OVH_INSERT_REQ,
  input wire logic TX_TRANSPORT_OVH_DATA,
  output logic TX_TRANSPORT_OVH_FRAME_MARK,
  output logic TX_TRANSPORT_OVH_ENABLE,
  input wire logic TX_PATH_OVH_CLOCK,
  input wire logic TX_PATH_OVH_INSERT_REQ,
  input wire logic TX_PATH_OVH_DATA,
  output logic TX_PATH_OVH_FRAME_MARK,
  output logic TX_PATH_OVH_ENABLE,
  output logic TX_PATH_OVH_VALID,
  input wire logic TX_ORDERWIRE_DATA,
  output logic TX_ORDERWIRE_ENABLE,
  output logic TX_ORDERWIRE_FRAME_MARK,
  input wire logic TX_SECTION_DCC_DATA,
  output logic TX_SECTION_DCC_ENABLE,
  input wire logic TX_LINE_DCC_DATA,
  output logic TX_LINE_DCC_ENABLE,
  // captured bytes towards the outgoing frame inserter
  output logic [7:0] TX_TRANSPORT_OVH_BYTE,
  output logic [7:0] TX_TRANSPORT_OVH_INDEX,
  output logic TX_TRANSPORT_OVH_INSERT,
  output logic TX_TRANSPORT_OVH_STB,
  output logic [7:0] TX_PATH_OVH_BYTE,
  output logic [7:0] TX_PATH_OVH_INDEX,
  output logic TX_PATH_OVH_INSERT,
  output logic TX_PATH_OVH_STB,
  output logic [7:0] TX_ORDERWIRE_BYTE,
  output logic [7:0] TX_ORDERWIRE_INDEX,
  output logic TX_ORDERWIRE_STB,
  output logic [7:0] TX_SECTION_DCC_BYTE,
  output logic [7:0] TX_SECTION_DCC_INDEX,
  output logic TX_SECTION_DCC_STB,
  output logic [7:0] TX_LINE_DCC_BYTE,
  output logic [7:0] TX_LINE_DCC_INDEX,
  output logic TX_LINE_DCC_STB,
  // receive serial pins
  input wire logic RX_TRANSPORT_OVH_CLOCK,
  output logic RX_TRANSPORT_OVH_DATA,
  output logic RX_TRANSPORT_OVH_FRAME_MARK,
  output logic RX_TRANSPORT_OVH_VALID,
  input wire logic RX_PATH_OVH_CLOCK,
  output logic RX_PATH_OVH_DATA,
  output logic RX_PATH_OVH_FRAME_MARK,
  output logic RX_PATH_OVH_VALID,
  output logic RX_ORDERWIRE_DATA,
  output logic RX_ORDERWIRE_FRAME_MARK,
  output logic RX_ORDERWIRE_VALID,
  output logic RX_SECTION_DCC_DATA,
  output logic RX_SECTION_DCC_VALID,
  output logic RX_LINE_DCC_DATA,
  output logic RX_LINE_DCC_VALID,
  // extracted bytes from the incoming frame processor
  input wire logic RX_TRANSPORT_OVH_LOAD,
  input wire logic [7:0] RX_TRANSPORT_OVH_LOAD_BYTE,
  output logic [7:0] RX_TRANSPORT_OVH_NEXT_INDEX,
  input wire logic RX_PATH_OVH_LOAD,
  input wire logic [7:0] RX_PATH_OVH_LOAD_BYTE,
  output logic [7:0] RX_PATH_OVH_NEXT_INDEX,
  input wire logic RX_ORDERWIRE_LOAD,
  input wire logic [7:0] RX_ORDERWIRE_LOAD_BYTE,
  output logic [7:0] RX_ORDERWIRE_NEXT_INDEX,
  input wire logic RX_SECTION_DCC_LOAD,
  input wire logic [7:0] RX_SECTION_DCC_LOAD_BYTE,
  output logic [7:0] RX_SECTION_DCC_NEXT_INDEX,
  input wire logic RX_LINE_DCC_LOAD,
  input wire logic [7:0] RX_LINE_DCC_LOAD_BYTE,
  output logic [7:0] RX_LINE_DCC_NEXT_INDEX
);
  localparam int N = ovh_port_pkg::LANES;

  logic [ovh_port_pkg::PIN_COUNT-1:0] pin_vec;
  logic [ovh_port_pkg::PIN_COUNT-1:0] pin_level;
  logic [ovh_port_pkg::PIN_COUNT-1:0] pin_rise;
  logic [ovh_port_pkg::PIN_COUNT-1:0] pin_fall;

  // per-lane strobes and serial inputs
  logic [N-1:0] tx_rise;
  logic [N-1:0] tx_fall;
  logic [N-1:0] rx_fall;
  logic [N-1:0] tx_bit;
  logic [N-1:0] tx_req;
  logic [N-1:0] rx_load;
  logic [7:0] rx_load_byte [N];

  // transmit lane state
  logic [10:0] tx_pos_reg [N];
  logic [N-1:0] tx_en_reg;
  logic [N-1:0] tx_frame_reg;
  logic [N-1:0] tx_first_reg;
  logic [6:0] tx_shift_reg [N];
  logic [N-1:0] tx_req_reg;
  logic [7:0] tx_byte_reg [N];
  logic [7:0] tx_index_reg [N];
  logic [N-1:0] tx_ins_reg;
  logic [N-1:0] tx_stb_reg;

  // receive lane state
  logic [10:0] rx_pos_reg [N];
  logic [7:0] rx_hold_reg [N];
  logic [N-1:0] rx_fresh_reg;
  logic [7:0] rx_shift_reg [N];
  logic [N-1:0] rx_data_reg;
  logic [N-1:0] rx_valid_reg;
  logic [N-1:0] rx_frame_reg;
  logic [7:0] rx_next_index_reg [N];
  logic [N-1:0] rx_copy;

  // every pin from outside passes the synchroniser
  assign pin_vec = {TX_LINE_DCC_DATA, TX_SECTION_DCC_DATA, TX_ORDERWIRE_DATA,
                    TX_PATH_OVH_DATA, TX_PATH_OVH_INSERT_REQ, TX_TRANSPORT_OVH_DATA,
                    TX_TRANSPORT_OVH_INSERT_REQ, RX_PATH_OVH_CLOCK,
                    RX_TRANSPORT_OVH_CLOCK, TX_PATH_OVH_CLOCK, TX_TRANSPORT_OVH_CLOCK};

  pin_sync #(
    .WIDTH(ovh_port_pkg::PIN_COUNT)
  ) u_pin_sync (
    .CLK(CLK),
    .RST(RST),
    .PIN(pin_vec),
    .LEVEL(pin_level),
    .RISE(pin_rise),
    .FALL(pin_fall)
  );

  // serial input bits per transmit lane
  assign tx_bit[ovh_port_pkg::LANE_TOH] = pin_level[ovh_port_pkg::PIN_TOH_DATA];
  assign tx_bit[ovh_port_pkg::LANE_OW] = pin_level[ovh_port_pkg::PIN_OW_DATA];
  assign tx_bit[ovh_port_pkg::LANE_SDCC] = pin_level[ovh_port_pkg::PIN_SDCC_DATA];
  assign tx_bit[ovh_port_pkg::LANE_LDCC] = pin_level[ovh_port_pkg::PIN_LDCC_DATA];
  assign tx_bit[ovh_port_pkg::LANE_POH] = pin_level[ovh_port_pkg::PIN_POH_DATA];
  assign tx_req[ovh_port_pkg::LANE_TOH] = pin_level[ovh_port_pkg::PIN_TOH_REQ];
  assign tx_req[ovh_port_pkg::LANE_OW] = 1'b1;
  assign tx_req[ovh_port_pkg::LANE_SDCC] = 1'b1;
  assign tx_req[ovh_port_pkg::LANE_LDCC] = 1'b1;
  assign tx_req[ovh_port_pkg::LANE_POH] = pin_level[ovh_port_pkg::PIN_POH_REQ];

  // byte loads from the incoming frame processor
  assign rx_load = {RX_PATH_OVH_LOAD, RX_LINE_DCC_LOAD, RX_SECTION_DCC_LOAD,
                    RX_ORDERWIRE_LOAD, RX_TRANSPORT_OVH_LOAD};
  assign rx_load_byte[ovh_port_pkg::LANE_TOH] = RX_TRANSPORT_OVH_LOAD_BYTE;
  assign rx_load_byte[ovh_port_pkg::LANE_OW] = RX_ORDERWIRE_LOAD_BYTE;
  assign rx_load_byte[ovh_port_pkg::LANE_SDCC] = RX_SECTION_DCC_LOAD_BYTE;
  assign rx_load_byte[ovh_port_pkg::LANE_LDCC] = RX_LINE_DCC_LOAD_BYTE;
  assign rx_load_byte[ovh_port_pkg::LANE_POH] = RX_PATH_OVH_LOAD_BYTE;

  for (genvar i = 0; i < N; i++) begin : g_lane
    localparam logic [10:0] LAST = 11'(ovh_port_pkg::LANE_FRAME_BITS[i] - 1);
    localparam logic [10:0] START = 11'(ovh_port_pkg::LANE_START[i]);
    localparam logic [10:0] STOP = 11'(ovh_port_pkg::LANE_START[i]
                                       + ovh_port_pkg::LANE_LEN[i]);
    localparam logic [7:0] LAST_IDX = 8'(ovh_port_pkg::LANE_LEN[i] / 8 - 1);
    logic [10:0] tx_pos_next;
    logic [10:0] tx_off_next;
    logic [10:0] tx_off;
    logic tx_in_next;
    logic [10:0] rx_pos_next;
    logic [10:0] rx_off_next;
    logic rx_in_next;

    // lane clock selection between transport and path port clocks
    assign tx_rise[i] = ovh_port_pkg::LANE_ON_POH[i] ?
                        pin_rise[ovh_port_pkg::PIN_TX_POH_CLK] :
                        pin_rise[ovh_port_pkg::PIN_TX_TOH_CLK];
    assign tx_fall[i] = ovh_port_pkg::LANE_ON_POH[i] ?
                        pin_fall[ovh_port_pkg::PIN_TX_POH_CLK] :
                        pin_fall[ovh_port_pkg::PIN_TX_TOH_CLK];
    assign rx_fall[i] = ovh_port_pkg::LANE_ON_POH[i] ?
                        pin_fall[ovh_port_pkg::PIN_RX_POH_CLK] :
                        pin_fall[ovh_port_pkg::PIN_RX_TOH_CLK];

    // transmit slot arithmetic
    assign tx_pos_next = (tx_pos_reg[i] == LAST) ? 11'h000 : tx_pos_reg[i] + 11'h001;
    assign tx_off_next = tx_pos_next - START;
    assign tx_off = tx_pos_reg[i] - START;
    assign tx_in_next = (tx_pos_next >= START) && (tx_pos_next < STOP);

    // slot advance and marker outputs on the falling edge
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        tx_pos_reg[i] <= LAST;
        tx_en_reg[i] <= 1'b0;
        tx_frame_reg[i] <= 1'b0;
        tx_first_reg[i] <= 1'b0;
      end else if (tx_fall[i]) begin
        tx_pos_reg[i] <= tx_pos_next;
        tx_en_reg[i] <= tx_in_next;
        tx_frame_reg[i] <= (tx_pos_next == START);
        tx_first_reg[i] <= tx_in_next && (tx_off_next[2:0] == 3'h0);
      end
    end

    // capture of request and data on the rising edge within the window
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        tx_shift_reg[i] <= 7'h00;
        tx_req_reg[i] <= 1'b0;
      end else if (tx_rise[i] && tx_en_reg[i]) begin
        tx_shift_reg[i] <= {tx_shift_reg[i][5:0], tx_bit[i]};
        if (tx_off[2:0] == 3'h0) begin
          tx_req_reg[i] <= tx_req[i];
        end
      end
    end

    // assembled byte handed to the inserter, msb first on the wire
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        tx_byte_reg[i] <= 8'h00;
        tx_index_reg[i] <= 8'h00;
        tx_ins_reg[i] <= 1'b0;
        tx_stb_reg[i] <= 1'b0;
      end else begin
        tx_stb_reg[i] <= 1'b0;
        if (tx_rise[i] && tx_en_reg[i] && (tx_off[2:0] == 3'h7)) begin
          tx_byte_reg[i] <= {tx_shift_reg[i], tx_bit[i]};
          tx_index_reg[i] <= tx_off[10:3];
          tx_ins_reg[i] <= tx_req_reg[i];
          tx_stb_reg[i] <= 1'b1;
        end
      end
    end

    // receive slot arithmetic
    assign rx_pos_next = (rx_pos_reg[i] == LAST) ? 11'h000 : rx_pos_reg[i] + 11'h001;
    assign rx_off_next = rx_pos_next - START;
    assign rx_in_next = (rx_pos_next >= START) && (rx_pos_next < STOP);
    assign rx_copy[i] = rx_fall[i] && rx_in_next && (rx_off_next[2:0] == 3'h0);

    // holding byte from the frame processor, a new load wins over the copy
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        rx_hold_reg[i] <= 8'h00;
        rx_fresh_reg[i] <= 1'b0;
      end else if (rx_load[i]) begin
        rx_hold_reg[i] <= rx_load_byte[i];
        rx_fresh_reg[i] <= 1'b1;
      end else if (rx_copy[i]) begin
        rx_fresh_reg[i] <= 1'b0;
      end
    end

    // serial output, markers and qualifier, all on the falling edge
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        rx_pos_reg[i] <= LAST;
        rx_shift_reg[i] <= 8'h00;
        rx_data_reg[i] <= 1'b0;
        rx_valid_reg[i] <= 1'b0;
        rx_frame_reg[i] <= 1'b0;
      end else if (rx_fall[i]) begin
        rx_pos_reg[i] <= rx_pos_next;
        rx_frame_reg[i] <= (rx_pos_next == START);
        if (rx_copy[i]) begin
          rx_shift_reg[i] <= {rx_hold_reg[i][6:0], 1'b0};
          rx_data_reg[i] <= rx_hold_reg[i][7];
          rx_valid_reg[i] <= rx_fresh_reg[i];
        end else if (rx_in_next) begin
          rx_shift_reg[i] <= {rx_shift_reg[i][6:0], 1'b0};
          rx_data_reg[i] <= rx_shift_reg[i][7];
        end else begin
          rx_data_reg[i] <= 1'b0;
          rx_valid_reg[i] <= 1'b0;
        end
      end
    end

    // index of the byte the frame processor should load next
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        rx_next_index_reg[i] <= 8'h00;
      end else if (rx_copy[i]) begin
        rx_next_index_reg[i] <= (rx_off_next[10:3] == LAST_IDX) ? 8'h00 :
                                rx_off_next[10:3] + 8'h01;
      end
    end
  end

  // transmit pin outputs
  assign TX_TRANSPORT_OVH_FRAME_MARK = tx_frame_reg[ovh_port_pkg::LANE_TOH];
  assign TX_TRANSPORT_OVH_ENABLE = tx_en_reg[ovh_port_pkg::LANE_TOH];
  assign TX_PATH_OVH_FRAME_MARK = tx_frame_reg[ovh_port_pkg::LANE_POH];
  assign TX_PATH_OVH_ENABLE = tx_en_reg[ovh_port_pkg::LANE_POH];
  assign TX_PATH_OVH_VALID = tx_first_reg[ovh_port_pkg::LANE_POH];
  assign TX_ORDERWIRE_ENABLE = tx_en_reg[ovh_port_pkg::LANE_OW];
  assign TX_ORDERWIRE_FRAME_MARK = tx_frame_reg[ovh_port_pkg::LANE_OW];
  assign TX_SECTION_DCC_ENABLE = tx_en_reg[ovh_port_pkg::LANE_SDCC];
  assign TX_LINE_DCC_ENABLE = tx_en_reg[ovh_port_pkg::LANE_LDCC];

  // captured bytes
  assign TX_TRANSPORT_OVH_BYTE = tx_byte_reg[ovh_port_pkg::LANE_TOH];
  assign TX_TRANSPORT_OVH_INDEX = tx_index_reg[ovh_port_pkg::LANE_TOH];
  assign TX_TRANSPORT_OVH_INSERT = tx_ins_reg[ovh_port_pkg::LANE_TOH];
  assign TX_TRANSPORT_OVH_STB = tx_stb_reg[ovh_port_pkg::LANE_TOH];
  assign TX_PATH_OVH_BYTE = tx_byte_reg[ovh_port_pkg::LANE_POH];
  assign TX_PATH_OVH_INDEX = tx_index_reg[ovh_port_pkg::LANE_POH];
  assign TX_PATH_OVH_INSERT = tx_ins_reg[ovh_port_pkg::LANE_POH];
  assign TX_PATH_OVH_STB = tx_stb_reg[ovh_port_pkg::LANE_POH];
  assign TX_ORDERWIRE_BYTE = tx_byte_reg[ovh_port_pkg::LANE_OW];
  assign TX_ORDERWIRE_INDEX = tx_index_reg[ovh_port_pkg::LANE_OW];
  assign TX_ORDERWIRE_STB = tx_stb_reg[ovh_port_pkg::LANE_OW];
  assign TX_SECTION_DCC_BYTE = tx_byte_reg[ovh_port_pkg::LANE_SDCC];
  assign TX_SECTION_DCC_INDEX = tx_index_reg[ovh_port_pkg::LANE_SDCC];
  assign TX_SECTION_DCC_STB = tx_stb_reg[ovh_port_pkg::LANE_SDCC];
  assign TX_LINE_DCC_BYTE = tx_byte_reg[ovh_port_pkg::LANE_LDCC];
  assign TX_LINE_DCC_INDEX = tx_index_reg[ovh_port_pkg::LANE_LDCC];
  assign TX_LINE_DCC_STB = tx_stb_reg[ovh_port_pkg::LANE_LDCC];

  // receive pin outputs
  assign RX_TRANSPORT_OVH_DATA = rx_data_reg[ovh_port_pkg::LANE_TOH];
  assign RX_TRANSPORT_OVH_FRAME_MARK = rx_frame_reg[ovh_port_pkg::LANE_TOH];
  assign RX_TRANSPORT_OVH_VALID = rx_valid_reg[ovh_port_pkg::LANE_TOH];
  assign RX_PATH_OVH_DATA = rx_data_reg[ovh_port_pkg::LANE_POH];
  assign RX_PATH_OVH_FRAME_MARK = rx_frame_reg[ovh_port_pkg::LANE_POH];
  assign RX_PATH_OVH_VALID = rx_valid_reg[ovh_port_pkg::LANE_POH];
  assign RX_ORDERWIRE_DATA = rx_data_reg[ovh_port_pkg::LANE_OW];
  assign RX_ORDERWIRE_FRAME_MARK = rx_frame_reg[ovh_port_pkg::LANE_OW];
  assign RX_ORDERWIRE_VALID = rx_valid_reg[ovh_port_pkg::LANE_OW];
  assign RX_SECTION_DCC_DATA = rx_data_reg[ovh_port_pkg::LANE_SDCC];
  assign RX_SECTION_DCC_VALID = rx_valid_reg[ovh_port_pkg::LANE_SDCC];
  assign RX_LINE_DCC_DATA = rx_data_reg[ovh_port_pkg::LANE_LDCC];
  assign RX_LINE_DCC_VALID = rx_valid_reg[ovh_port_pkg::LANE_LDCC];
  assign RX_TRANSPORT_OVH_NEXT_INDEX = rx_next_index_reg[ovh_port_pkg::LANE_TOH];
  assign RX_PATH_OVH_NEXT_INDEX = rx_next_index_reg[ovh_port_pkg::LANE_POH];
  assign RX_ORDERWIRE_NEXT_INDEX = rx_next_index_reg[ovh_port_pkg::LANE_OW];
  assign RX_SECTION_DCC_NEXT_INDEX = rx_next_index_reg[ovh_port_pkg::LANE_SDCC];
  assign RX_LINE_DCC_NEXT_INDEX = rx_next_index_reg[ovh_port_pkg::LANE_LDCC];
endmodule
`default_nettype wire

// ==== testbench/overhead_ports_assertions.sv ====
// timing relations between the port clocks and the access port outputs
`timescale 1ns/1ns
`default_nettype none
module overhead_ports_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_TRANSPORT_OVH_CLOCK,
  input wire logic TX_TRANSPORT_OVH_FRAME_MARK,
  input wire logic TX_TRANSPORT_OVH_ENABLE,
  input wire logic TX_PATH_OVH_CLOCK,
  input wire logic TX_PATH_OVH_VALID,
  input wire logic TX_PATH_OVH_STB,
  input wire logic TX_ORDERWIRE_STB,
  input wire logic [7:0] TX_ORDERWIRE_INDEX,
  input wire logic RX_TRANSPORT_OVH_CLOCK,
  input wire logic RX_TRANSPORT_OVH_FRAME_MARK,
  input wire logic RX_SECTION_DCC_VALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // outputs move only while the port clock is low
  a_mark_on_low: assert property ($rose(TX_TRANSPORT_OVH_FRAME_MARK) |-> !TX_TRANSPORT_OVH_CLOCK)
    else $error("tx mark moved, clock high");
  a_pvalid_on_low: assert property ($changed(TX_PATH_OVH_VALID) |-> !TX_PATH_OVH_CLOCK)
    else $error("tx path valid moved, clock high");
  a_rxmark_on_low: assert property ($rose(RX_TRANSPORT_OVH_FRAME_MARK) |-> !RX_TRANSPORT_OVH_CLOCK)
    else $error("rx mark moved, clock high");
  a_sdcc_on_low: assert property ($changed(RX_SECTION_DCC_VALID) |-> !RX_TRANSPORT_OVH_CLOCK)
    else $error("rx sdcc valid moved, clock high");
  // mark inside window, stands a slot
  a_mark_enable: assert property (TX_TRANSPORT_OVH_FRAME_MARK |-> TX_TRANSPORT_OVH_ENABLE)
    else $error("tx mark without enable");
  a_rxmark_hold: assert property ($rose(RX_TRANSPORT_OVH_FRAME_MARK) |-> RX_TRANSPORT_OVH_FRAME_MARK[*8])
    else $error("rx mark too short");
  // byte strobes spaced, index in window
  a_pstb_gap: assert property (TX_PATH_OVH_STB |=> (!TX_PATH_OVH_STB)[*8])
    else $error("path strobes too close");
  a_ow_index: assert property (TX_ORDERWIRE_STB |-> TX_ORDERWIRE_INDEX < 8'h03)
    else $error("orderwire index too big");
  cover property (TX_ORDERWIRE_STB);
  cover property ($fell(RX_SECTION_DCC_VALID));
  cover property (TX_PATH_OVH_STB ##1 !TX_PATH_OVH_STB);
endmodule
`default_nettype wire

// ==== testbench/ovh_user_model.sv ====
// user logic that serialises overhead bytes into the transmit ports
`timescale 1ns/1ns
`default_nettype none
module ovh_user_model (
  input wire logic rst,
  input wire logic toh_clk,
  input wire logic poh_clk,
  input wire logic [39:0] salt,
  output logic [4:0] bits,
  output logic [4:0] req
);
  for (genvar l = 0; l < 5; l++) begin : g_lane
    localparam int S = ovh_port_pkg::LANE_START[l];
    localparam int L = ovh_port_pkg::LANE_LEN[l];
    localparam int N = ovh_port_pkg::LANE_FRAME_BITS[l];
    wire pclk = ovh_port_pkg::LANE_ON_POH[l] ? poh_clk : toh_clk;
    int slot = -1;
    logic [7:0] b;
    // one bit per port clock fall, msb first; idle line toggles
    always @(negedge pclk or posedge rst) begin
      if (rst) begin
        slot = -1;
        bits[l] <= 1'b0;
        req[l] <= 1'b0;
      end else begin
        slot = (slot + 1) % N;
        b = salt[l*8 +: 8] ^ 8'((slot - S) / 8 * 37);
        if (slot >= S && slot < S + L) begin
          bits[l] <= b[7 - (slot - S) % 8];
          req[l] <= ~b[0];
        end else begin
          bits[l] <= ~bits[l];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench of the overhead access ports
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst;
  logic run = 1'b0;
  logic pc [4] = '{1'b0, 1'b0, 1'b0, 1'b0};
  logic [39:0] ts = 40'h0, rs = 40'h0;
  logic [4:0] ld = 5'h00;
  logic [7:0] lb [5] = '{default: 8'h00};
  logic [7:0] sh [5];
  wire [4:0] pb, pq, tf, tq, ten, tstb, rd, rv, rf;
  wire pvld;
  wire [7:0] tby [5], ti [5], nx [5];
  int errors = 0, total_checks = 0, cycles = 0;
  int skip [5], ei [5], got [5], sl [4] = '{-1, -1, -1, -1};
  function automatic logic [7:0] pat(input logic [7:0] s, input int i);
    return s ^ 8'(i * 37);
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_byte({7'h00, g}, {7'h00, e}, m);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ovh_user_model user (.rst(rst), .toh_clk(pc[0]), .poh_clk(pc[1]), .salt(ts), .bits(pb),
    .req(pq));
  overhead_ports uut (.CLK(clk), .RST(rst),
    .TX_TRANSPORT_OVH_CLOCK(pc[0]), .TX_TRANSPORT_OVH_INSERT_REQ(pq[0]),
    .TX_TRANSPORT_OVH_DATA(pb[0]), .TX_TRANSPORT_OVH_FRAME_MARK(tf[0]),
    .TX_TRANSPORT_OVH_ENABLE(ten[0]), .TX_PATH_OVH_CLOCK(pc[1]),
    .TX_PATH_OVH_INSERT_REQ(pq[4]), .TX_PATH_OVH_DATA(pb[4]), .TX_PATH_OVH_FRAME_MARK(tf[4]),
    .TX_PATH_OVH_ENABLE(ten[4]), .TX_PATH_OVH_VALID(pvld), .TX_ORDERWIRE_DATA(pb[1]),
    .TX_ORDERWIRE_ENABLE(ten[1]), .TX_ORDERWIRE_FRAME_MARK(tf[1]),
    .TX_SECTION_DCC_DATA(pb[2]), .TX_SECTION_DCC_ENABLE(ten[2]),
    .TX_LINE_DCC_DATA(pb[3]), .TX_LINE_DCC_ENABLE(ten[3]),
    .TX_TRANSPORT_OVH_BYTE(tby[0]), .TX_TRANSPORT_OVH_INDEX(ti[0]),
    .TX_TRANSPORT_OVH_INSERT(tq[0]), .TX_TRANSPORT_OVH_STB(tstb[0]),
    .TX_PATH_OVH_BYTE(tby[4]), .TX_PATH_OVH_INDEX(ti[4]), .TX_PATH_OVH_INSERT(tq[4]),
    .TX_PATH_OVH_STB(tstb[4]), .TX_ORDERWIRE_BYTE(tby[1]), .TX_ORDERWIRE_INDEX(ti[1]),
    .TX_ORDERWIRE_STB(tstb[1]), .TX_SECTION_DCC_BYTE(tby[2]), .TX_SECTION_DCC_INDEX(ti[2]),
    .TX_SECTION_DCC_STB(tstb[2]), .TX_LINE_DCC_BYTE(tby[3]), .TX_LINE_DCC_INDEX(ti[3]),
    .TX_LINE_DCC_STB(tstb[3]), .RX_TRANSPORT_OVH_CLOCK(pc[2]), .RX_TRANSPORT_OVH_DATA(rd[0]),
    .RX_TRANSPORT_OVH_FRAME_MARK(rf[0]), .RX_TRANSPORT_OVH_VALID(rv[0]),
    .RX_PATH_OVH_CLOCK(pc[3]), .RX_PATH_OVH_DATA(rd[4]), .RX_PATH_OVH_FRAME_MARK(rf[4]),
    .RX_PATH_OVH_VALID(rv[4]), .RX_ORDERWIRE_DATA(rd[1]), .RX_ORDERWIRE_FRAME_MARK(rf[1]),
    .RX_ORDERWIRE_VALID(rv[1]), .RX_SECTION_DCC_DATA(rd[2]), .RX_SECTION_DCC_VALID(rv[2]),
    .RX_LINE_DCC_DATA(rd[3]), .RX_LINE_DCC_VALID(rv[3]),
    .RX_TRANSPORT_OVH_LOAD(ld[0]), .RX_TRANSPORT_OVH_LOAD_BYTE(lb[0]),
    .RX_TRANSPORT_OVH_NEXT_INDEX(nx[0]), .RX_PATH_OVH_LOAD(ld[4]),
    .RX_PATH_OVH_LOAD_BYTE(lb[4]), .RX_PATH_OVH_NEXT_INDEX(nx[4]),
    .RX_ORDERWIRE_LOAD(ld[1]), .RX_ORDERWIRE_LOAD_BYTE(lb[1]), .RX_ORDERWIRE_NEXT_INDEX(nx[1]),
    .RX_SECTION_DCC_LOAD(ld[2]), .RX_SECTION_DCC_LOAD_BYTE(lb[2]),
    .RX_SECTION_DCC_NEXT_INDEX(nx[2]), .RX_LINE_DCC_LOAD(ld[3]),
    .RX_LINE_DCC_LOAD_BYTE(lb[3]), .RX_LINE_DCC_NEXT_INDEX(nx[3]));
  // core clock and four free port clocks, stopped low while reset
  initial forever #5 clk = ~clk;
  for (genvar c = 0; c < 4; c++) begin : g_pc
    initial begin
      #(c * 31);
      forever begin
        if (!run) wait (run);
        #62 pc[c] = 1'b1;
        #63 pc[c] = 1'b0;
      end
    end
    always @(negedge pc[c] or posedge rst) sl[c] <= rst ? -1 : (sl[c] + 1) % (c % 2 ? 72 : 1944);
  end
  // per lane tx and rx checks
  for (genvar l = 0; l < 5; l++) begin : g_ln
    localparam int P = ovh_port_pkg::LANE_ON_POH[l];
    localparam int S = ovh_port_pkg::LANE_START[l];
    localparam int L = ovh_port_pkg::LANE_LEN[l];
    logic [7:0] e;
    always @(posedge pc[P]) begin
      if (!rst && sl[P] >= 0) begin
        chk_bit(ten[l], sl[P] >= S && sl[P] < S + L, "tx enable");
        if (l % 4 < 2) chk_bit(tf[l], sl[P] == S, "tx mark");
        if (l == 4) chk_bit(pvld, sl[P] % 8 == 0, "tx path valid");
      end
    end
    always @(posedge clk) begin
      if (rst) ei[l] = 0;
      else if (tstb[l] === 1'b1) begin
        e = pat(ts[l*8 +: 8], ei[l]);
        chk_byte(tby[l], e, "tx byte");
        chk_byte(ti[l], 8'(ei[l]), "tx index");
        if (l % 4 == 0) chk_bit(tq[l], ~e[0], "tx insert");
        ei[l] = (ei[l] + 1) % (L / 8);
      end
      ld[l] <= !rst && int'(nx[l]) != got[l] && int'(nx[l]) != skip[l];
      lb[l] <= pat(rs[l*8 +: 8], nx[l]);
      got[l] = rst ? -1 : int'(nx[l]);
    end
    always @(posedge pc[P + 2]) begin
      int p;
      p = sl[P + 2] - S;
      if (!rst && sl[P + 2] >= 0) begin
        if (l % 4 < 2) chk_bit(rf[l], p == 0, "rx mark");
        if (p >= 0 && p < L) begin
          sh[l] = {sh[l][6:0], rd[l]};
          chk_bit(rv[l], p / 8 != skip[l], "rx valid");
          if (p % 8 == 0) chk_byte(nx[l], 8'((p / 8 + 1) % (L / 8)), "rx index");
          if (p % 8 == 7) chk_byte(sh[l], pat(rs[l*8 +: 8], p / 8 - int'(p / 8 == skip[l])),
            "rx byte");
        end else begin
          chk_bit(rd[l] | rv[l], 1'b0, "rx idle");
        end
      end
    end
  end
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      $display("CHECK FAILED at %0t: run too long", $time);
      test_done();
    end
  end
  // random salts, then corner salts after mid-run reset
  initial begin
    rst = 1'b1;
    void'($urandom(87472));
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk);
      rst <= 1'b1;
      run <= 1'b0;
      for (int l = 0; l < 5; l++) skip[l] = 1 + $urandom % (ovh_port_pkg::LANE_LEN[l] / 8 - 1);
      ts <= ph ? 40'hFF00FF00FF : {$urandom, 8'($urandom)};
      rs <= ph ? 40'h00FF00FF00 : {$urandom, 8'($urandom)};
      repeat (12) @(posedge clk);
      chk_byte({1'b0, tstb | ten | rd | rv, tf[0], pvld}, 8'h00, "reset outputs");
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      run <= 1'b1;
      repeat (ph ? 26000 : 50000) @(posedge clk);
      $display("test %0d done: checks %0d errors %0d", ph, total_checks, errors);
    end
    test_done();
  end
endmodule
bind overhead_ports overhead_ports_assertions chk (.CLK(CLK), .RST(RST),
  .TX_TRANSPORT_OVH_CLOCK(TX_TRANSPORT_OVH_CLOCK),
  .TX_TRANSPORT_OVH_FRAME_MARK(TX_TRANSPORT_OVH_FRAME_MARK),
  .TX_TRANSPORT_OVH_ENABLE(TX_TRANSPORT_OVH_ENABLE), .TX_PATH_OVH_CLOCK(TX_PATH_OVH_CLOCK),
  .TX_PATH_OVH_VALID(TX_PATH_OVH_VALID), .TX_PATH_OVH_STB(TX_PATH_OVH_STB),
  .TX_ORDERWIRE_STB(TX_ORDERWIRE_STB), .TX_ORDERWIRE_INDEX(TX_ORDERWIRE_INDEX),
  .RX_TRANSPORT_OVH_CLOCK(RX_TRANSPORT_OVH_CLOCK),
  .RX_TRANSPORT_OVH_FRAME_MARK(RX_TRANSPORT_OVH_FRAME_MARK),
  .RX_SECTION_DCC_VALID(RX_SECTION_DCC_VALID));
`default_nettype wire
